// ---- rbt_checker.sv ----
`timescale 1ns/1ps
module rbt_checker(input wire core_clk, rst_b, a_to_b_transparent, a_to_b_capture_clk, a_to_b_clk_gate_n,
  input wire a_to_b_drive_en_n,
  input wire [17:0] sideOneBusIn, sideTwoBusOut, sideTwoBusOe, sideOneBusOut, sideOneBusOe);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_rst; $rose(rst_b) |-> (sideTwoBusOe | sideTwoBusOut) == 0; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_rst_a; $rose(rst_b) |-> (sideOneBusOe | sideOneBusOut) == 0; endproperty
  a_rst_a: assert property (p_rst_a) else $error("reset a side");
  property p_cap; $rose(a_to_b_capture_clk) && !a_to_b_transparent && !a_to_b_clk_gate_n |->
    ##5 sideTwoBusOut == $past(sideOneBusIn, 5); endproperty
  a_cap: assert property (p_cap) else $error("capture");
  property p_oe_off; a_to_b_drive_en_n [*5] |=> sideTwoBusOe == 18'h0; endproperty
  a_oe_off: assert property (p_oe_off) else $error("drive off");
  property p_oe_on; !a_to_b_drive_en_n [*5] |=> sideTwoBusOe == 18'h3ffff; endproperty
  a_oe_on: assert property (p_oe_on) else $error("drive on");
  property p_follow; (a_to_b_transparent && $stable(sideOneBusIn)) [*6] |=> sideTwoBusOut == $past(sideOneBusIn);
  endproperty
  a_follow: assert property (p_follow) else $error("follow");
  property p_hold; (!a_to_b_transparent && a_to_b_clk_gate_n) [*6] |=> $stable(sideTwoBusOut); endproperty
  a_hold: assert property (p_hold) else $error("hold");
endmodule
bind rbt_transceiver rbt_checker u_chk (.*);

// ---- rbt_defines.vh ----
`ifndef RBT_DEFINES_VH
`define RBT_DEFINES_VH

// data bits carried by each path
`define RBT_WIDTH 18
// path indices in the packed control vectors
`define RBT_PATH_AB 0
`define RBT_PATH_BA 1
// stored data after reset
`define RBT_STORE_RST 18'h00000
// input filter defaults: drive enables idle high (off), the rest low
`define RBT_DRIVE_N_RST 2'h3
`define RBT_CTRL_RST 2'h0
`define RBT_DATA_RST 18'h00000

`endif

// ---- rbt_far.sv ----
`timescale 1ns/1ps
module rbt_far(input wire [17:0] o, e, d, output wire [17:0] p);
  assign p = (e & o) | (~e & d);
endmodule

// ---- rbt_transceiver.v ----
// Notes on behaviour
// - there are two independent 18-bit paths, A to B and B to A, each with its own drive enable, transparent, capture clock and clock gate.
// - data passes through each path without inversion.
// - while a path is transparent its output follows the source bus regardless of clock and clock gate.
// - with transparency off and the capture clock steady, the path holds its stored value.
// - with transparency off and clock gate low, a rising capture clock edge stores the source bus and presents it.
// - an active-low drive enable drives the destination bus when low and releases all 18 pins when high.
// - with clock gate high and transparency off, capture clock edges are ignored.
// - the B to A path behaves like the A to B path with the A bus as destination.
`timescale 1ns/1ps
`include "rbt_defines.vh"

// three-stage pin filter: a change is taken once stages two and three agree
module rbt_pin_filter #(
  parameter W = 1,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire core_clk,
  input wire rst_b,
  input wire [W-1:0] pinIn,
  output reg [W-1:0] clean_reg
);
  reg [W-1:0] stage1_reg;
  reg [W-1:0] stage2_reg;
  reg [W-1:0] stage3_reg;
  genvar i;

  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1_reg <= INIT;
      stage2_reg <= INIT;
      stage3_reg <= INIT;
    end else begin
      stage1_reg <= pinIn;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // per bit, so a skewed bus settles bit by bit rather than stalling whole
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          clean_reg[i] <= INIT[i];
        end else if (stage2_reg[i] == stage3_reg[i]) begin
          clean_reg[i] <= stage3_reg[i];
        end
      end
    end
  endgenerate
endmodule

module rbt_transceiver (
  input wire core_clk,
  input wire rst_b,
  input wire a_to_b_drive_en_n,
  input wire b_to_a_drive_en_n,
  input wire a_to_b_transparent,
  input wire b_to_a_transparent,
  input wire a_to_b_capture_clk,
  input wire b_to_a_capture_clk,
  input wire a_to_b_clk_gate_n,
  input wire b_to_a_clk_gate_n,
  input wire [`RBT_WIDTH-1:0] sideOneBusIn,
  output wire [`RBT_WIDTH-1:0] sideOneBusOut,
  output wire [`RBT_WIDTH-1:0] sideOneBusOe,
  input wire [`RBT_WIDTH-1:0] sideTwoBusIn,
  output wire [`RBT_WIDTH-1:0] sideTwoBusOut,
  output wire [`RBT_WIDTH-1:0] sideTwoBusOe
);
  wire [1:0] driveN;
  wire [1:0] transp;
  wire [1:0] capClk;
  wire [1:0] gateN;
  wire [2*`RBT_WIDTH-1:0] srcClean;
  reg [1:0] capPrev_reg;
  reg [`RBT_WIDTH-1:0] store_reg [0:1];
  reg [`RBT_WIDTH-1:0] oe_reg [0:1];
  genvar p;

  rbt_pin_filter #(.W(2), .INIT(`RBT_DRIVE_N_RST)) u_drive (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinIn({b_to_a_drive_en_n, a_to_b_drive_en_n}),
    .clean_reg(driveN)
  );
  rbt_pin_filter #(.W(2), .INIT(`RBT_CTRL_RST)) u_transp (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinIn({b_to_a_transparent, a_to_b_transparent}),
    .clean_reg(transp)
  );
  rbt_pin_filter #(.W(2), .INIT(`RBT_CTRL_RST)) u_cap (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinIn({b_to_a_capture_clk, a_to_b_capture_clk}),
    .clean_reg(capClk)
  );
  rbt_pin_filter #(.W(2), .INIT(`RBT_CTRL_RST)) u_gate (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinIn({b_to_a_clk_gate_n, a_to_b_clk_gate_n}),
    .clean_reg(gateN)
  );
  // our own driven value loops back on the in side; harmless, it equals the store
  rbt_pin_filter #(.W(2*`RBT_WIDTH), .INIT({`RBT_DATA_RST, `RBT_DATA_RST})) u_data (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .pinIn({sideTwoBusIn, sideOneBusIn}),
    .clean_reg(srcClean)
  );

  // one decode for both paths, so the two directions cannot drift apart
  function rbt_capture_hit;
    input transpIn;
    input gateNIn;
    input clkNow;
    input clkPrev;
    begin
      rbt_capture_hit = !transpIn && !gateNIn && clkNow && !clkPrev;
    end
  endfunction

  // follow and capture both load the filtered source
  function rbt_load_hit;
    input transpIn;
    input gateNIn;
    input clkNow;
    input clkPrev;
    begin
      rbt_load_hit = transpIn || rbt_capture_hit(transpIn, gateNIn, clkNow, clkPrev);
    end
  endfunction

  // path 0 is A to B, path 1 is B to A; identical logic for both
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_path
      wire [`RBT_WIDTH-1:0] srcPath;
      wire loadHit;
      assign srcPath = srcClean[p*`RBT_WIDTH +: `RBT_WIDTH];
      assign loadHit = rbt_load_hit(transp[p], gateN[p], capClk[p], capPrev_reg[p]);
      always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
          capPrev_reg[p] <= 1'b0;
          store_reg[p] <= `RBT_STORE_RST;
          oe_reg[p] <= {`RBT_WIDTH{1'b0}};
        end else begin
          capPrev_reg[p] <= capClk[p];
          oe_reg[p] <= {`RBT_WIDTH{~driveN[p]}};
          if (loadHit) begin
            store_reg[p] <= srcPath;
          end
          // otherwise hold: steady clock or gated edge
          // store keeps the last followed value as transparency drops
        end
      end
    end
  endgenerate

  assign sideTwoBusOut = store_reg[`RBT_PATH_AB];
  assign sideTwoBusOe = oe_reg[`RBT_PATH_AB];
  assign sideOneBusOut = store_reg[`RBT_PATH_BA];
  assign sideOneBusOe = oe_reg[`RBT_PATH_BA];
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  reg core_clk = 0, rst_b = 0, oeA = 1, oeB = 1, leA = 0, cpA = 0, cpB = 0, geA = 0;
  reg [17:0] dA = 0;
  wire [17:0] aOut, aOe, bOut, bOe, aBus, bBus;
  integer n_errors = 0, tests_run = 0, cyc = 0;
  rbt_transceiver u_dut(.core_clk(core_clk), .rst_b(rst_b), .a_to_b_drive_en_n(oeA), .b_to_a_drive_en_n(oeB),
    .a_to_b_transparent(leA), .b_to_a_transparent(1'b0), .a_to_b_capture_clk(cpA), .b_to_a_capture_clk(cpB),
    .a_to_b_clk_gate_n(geA), .b_to_a_clk_gate_n(1'b0), .sideOneBusIn(aBus), .sideOneBusOut(aOut),
    .sideOneBusOe(aOe), .sideTwoBusIn(bBus), .sideTwoBusOut(bOut), .sideTwoBusOe(bOe));
  rbt_far u_a(.o(aOut), .e(aOe), .d(dA), .p(aBus));
  rbt_far u_b(.o(bOut), .e(bOe), .d(18'h3c0f1), .p(bBus));
  initial forever #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 400) begin n_errors++; wrap_up; end
  end
  task chk(input [17:0] got, exp);
    tests_run++;
    if (got !== exp) begin n_errors++; $display("MISMATCH %0t bus", $time); end
  endtask
  // waits past the edge so its updates have landed
  task w(input integer n); repeat (n) @(posedge core_clk); #1; endtask
  task wrap_up;
    $display("errors %0d of %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task t_flow;
    leA <= 1; oeA <= 0; dA <= 18'h2a5c3; w(8);
    chk(bBus, 18'h2a5c3);
    chk(bOe, 18'h3ffff);
    leA <= 0; geA <= 1; w(6); dA <= 18'h15a3c; w(7);
    chk(bBus, 18'h2a5c3);
  endtask
  task t_clk;
    cpA <= 1; w(6); chk(bBus, 18'h2a5c3);
    cpA <= 0; geA <= 0; w(6); cpA <= 1; w(6);
    chk(bBus, 18'h15a3c);
    oeA <= 1; w(6); chk(bOe, 18'h0);
  endtask
  task t_back;
    oeB <= 0; cpB <= 1; w(6); chk(aBus, 18'h3c0f1);
  endtask
  initial begin
    w(5); rst_b <= 1; w(1); chk(aOe | bOe | aOut | bOut, 18'h0);
    t_flow; t_clk; t_back; wrap_up;
  end
endmodule
